// ==== rtl/vdcr_cfg.svh ====
// Offsets, field codes, reset values and timing counts of the register group
`ifndef VDCR_CFG_SVH
`define VDCR_CFG_SVH

// ************************************************************
// Subaddresses
// ************************************************************
`define VDCR_SA_MISC 8'h17
`define VDCR_SA_GAIN 8'h18
`define VDCR_SA_OFFS 8'h19
`define VDCR_SA_KILL 8'h1a
`define VDCR_SA_CHRO 8'h1b
`define VDCR_SA_CMB1 8'h1c
`define VDCR_SA_CMB2 8'h1d
`define VDCR_SA_ST1 8'h1e
`define VDCR_SA_ST2 8'h1f

// ************************************************************
// Reset values (recommended settings where given)
// ************************************************************
`define VDCR_RST_MISC 8'h18
`define VDCR_RST_GAIN 8'h40
`define VDCR_RST_OFFS 8'h80
`define VDCR_RST_KILL 8'h77
`define VDCR_RST_CHRO 8'h42
`define VDCR_RST_CMB1 8'ha9
`define VDCR_RST_CMB2 8'h01

// ************************************************************
// Field codes and constants
// ************************************************************
`define VDCR_STD_SEARCH_LATENCY_RSVD 3'h0
`define VDCR_STD_SEARCH_LATENCY_DEF 3'h3
`define VDCR_GAIN_NOM 8'h80
`define VDCR_OFFS_ZERO 8'h80
`define VDCR_SYNC_STAGES 3

`endif

// ==== rtl/vdcr_field_ctl.sv ====
// Field-rate timing helpers: vertical gate, latency counter, sequence strobe
`timescale 1ns/1ps
`default_nettype none
`include "vdcr_cfg.svh"

module vdcr_field_ctl (
  input wire logic clk_sys_i,            // System clock
  input wire logic rst_i,                // Async reset, active high
  input wire logic field_start_i,        // One-cycle field start pulse
  input wire logic line_start_i,         // One-cycle line start pulse
  input wire logic field2_i,             // High during the second field
  input wire logic [8:0] line_num_i,     // Current line number
  input wire logic [8:0] gate_start_i,   // Gate start line
  input wire logic [8:0] gate_stop_i,    // Gate stop line
  input wire logic alt_gate_i,           // Gate one line early in field 2
  input wire logic [2:0] latency_i,      // Search latency in fields
  input wire logic fast_seq_i,           // Correct sequence every line
  output logic vertical_window_pulse_o,  // Vertical gate
  output logic std_search_step_o,        // Standard search step pulse
  output logic seq_correct_o             // Colour sequence correction pulse
);
  logic [2:0] field_cnt;
  logic [8:0] start_eff;
  logic [8:0] stop_eff;
  logic early;
  logic [2:0] lat_eff;
  logic lat_done;
  logic next_gate;

  assign early = alt_gate_i & field2_i;
  assign start_eff = early ? 9'(gate_start_i - 9'h1) : gate_start_i;
  assign stop_eff = early ? 9'(gate_stop_i - 9'h1) : gate_stop_i;
  assign next_gate = (line_num_i == start_eff) ? 1'b1 :
                     (line_num_i == stop_eff) ? 1'b0 :
                     vertical_window_pulse_o;

  assign lat_eff = (latency_i == `VDCR_STD_SEARCH_LATENCY_RSVD) ? `VDCR_STD_SEARCH_LATENCY_DEF : latency_i;
  assign lat_done = field_start_i && (field_cnt + 3'h1 >= lat_eff);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vertical_window_pulse_o <= 1'b0;
      field_cnt <= 3'h0;
      std_search_step_o <= 1'b0;
      seq_correct_o <= 1'b0;
    end
    else
    begin
      if (line_start_i)
        vertical_window_pulse_o <= next_gate;
      std_search_step_o <= lat_done;
      if (lat_done)
        field_cnt <= 3'h0;
      else if (field_start_i)
        field_cnt <= field_cnt + 3'h1;
      seq_correct_o <= fast_seq_i ? line_start_i : field_start_i;
    end
  end
endmodule // vdcr_field_ctl
`default_nettype wire

// ==== rtl/vdcr_pkg.sv ====
// Types shared by the video decoder control and status register group
package vdcr_pkg;

  typedef enum logic [1:0] {
    VDCR_STD_NONE = 2'h0,
    VDCR_STD_NTSC = 2'h1,
    VDCR_STD_PAL = 2'h2,
    VDCR_STD_SECAM = 2'h3
  } vdcr_std_t;

  // Host access phases, Gray coded along idle, write, read
  typedef enum logic [1:0] {
    VDCR_IDLE = 2'h0,
    VDCR_WRITE = 2'h1,
    VDCR_READ = 2'h3
  } vdcr_state_t;

  typedef struct packed {
    logic gate_start_msb;
    logic gate_stop_msb;
    logic alt_gate_position;
    logic [2:0] std_search_latency;
    logic half_line_clock_out_en_n;
    logic line_clock_out_en_n;
    logic [7:0] raw_gain_code;
    logic [7:0] raw_offset_code;
    logic [3:0] secam_killer_threshold;
    logic [3:0] quad_killer_threshold;
    logic [1:0] vcr_detect_threshold;
    logic colour_limit_en;
    logic fast_sequence_correct;
    logic [1:0] horiz_diff_gain;
    logic [1:0] vert_diff_gain;
    logic [1:0] median_gain;
    logic [1:0] comb_threshold;
    logic [1:0] vert_diff_threshold;
  } vdcr_ctrl_t;

  typedef struct packed {
    vdcr_std_t detected_colour_std;
    logic white_peak_active;
    logic gain_bottom_limited;
    logic gain_top_limited;
    logic slow_time_const_active;
    logic horiz_locked;
    logic standard_field_length;
    logic capture_ready;
    logic copy_protect_seen;
    logic colourstripe_seen;
    logic colourstripe_four_line;
    logic stable_timebase;
    logic field_rate_60;
    logic vert_locked;
    logic interlaced;
  } vdcr_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vdcr_req_t;

endpackage : vdcr_pkg

// ==== rtl/vdcr_regs.sv ====
// Control and status register group of the multi-standard video decoder
`timescale 1ns/1ps
`default_nettype none
`include "vdcr_cfg.svh"

module vdcr_regs
  import vdcr_pkg::*;
(
  input wire logic clk_sys_i,                 // Line-locked system clock
  input wire logic rst_i,                     // Async reset, active high
  input wire vdcr_pkg::vdcr_req_t req_i,      // Host subaddress access
  output logic [7:0] rdata_o,                 // Read data, registered
  output logic rvalid_o,                      // Read data valid pulse
  input wire vdcr_pkg::vdcr_status_t stat_i,  // Live decoder status
  input wire logic interlace_pin_i,           // Async interlace detect
  input wire logic field_start_i,             // Field start pulse
  input wire logic line_start_i,              // Line start pulse
  input wire logic field2_i,                  // Second field flag
  input wire logic [8:0] line_num_i,          // Line number
  input wire logic [7:0] gate_start_lsb_i,    // Gate start bits 7..0
  input wire logic [7:0] gate_stop_lsb_i,     // Gate stop bits 7..0
  input wire logic [7:0] raw_data_i,          // Raw ADC sample
  input wire logic line_clk_i,                // Line-locked clock level
  input wire logic half_line_clk_i,           // Half-rate line clock level
  output vdcr_pkg::vdcr_ctrl_t ctrl_o,        // Control fields
  output logic [7:0] raw_data_o,              // Scaled raw sample
  output logic line_clk_o,                    // Line clock pin out
  output logic line_clk_oe_n_o,               // Line clock enable, low drives
  output logic half_line_clk_o,               // Half clock pin out
  output logic half_line_clk_oe_n_o,          // Half clock enable, low drives
  output logic vertical_window_pulse_o,       // Vertical gate
  output logic std_search_step_o,             // Standard search step
  output logic seq_correct_o,                 // Sequence correction strobe
  output logic [3:0] killer_thr_o,            // Active colour killer level
  output logic colour_limit_o                 // Colour limiter active
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] r_misc;
  logic [7:0] r_gain;
  logic [7:0] r_offs;
  logic [7:0] r_kill;
  logic [7:0] r_chro;
  logic [7:0] r_cmb1;
  logic [7:0] r_cmb2;
  vdcr_state_t state;
  vdcr_state_t next_state;
  logic interlace_sync;

  // ************************************************************
  // Field decode
  // ************************************************************
  // gate ninth bits
  assign ctrl_o.gate_start_msb = r_misc[0];
  assign ctrl_o.gate_stop_msb = r_misc[1];
  assign ctrl_o.alt_gate_position = r_misc[2];
  assign ctrl_o.std_search_latency = r_misc[5:3];
  assign ctrl_o.half_line_clock_out_en_n = r_misc[6];
  assign ctrl_o.line_clock_out_en_n = r_misc[7];
  assign ctrl_o.raw_gain_code = r_gain;
  assign ctrl_o.raw_offset_code = r_offs;
  assign ctrl_o.secam_killer_threshold = r_kill[3:0];
  assign ctrl_o.quad_killer_threshold = r_kill[7:4];
  assign ctrl_o.vcr_detect_threshold = r_chro[7:6];
  assign ctrl_o.colour_limit_en = r_chro[1];
  assign ctrl_o.fast_sequence_correct = r_chro[0];
  assign ctrl_o.horiz_diff_gain = r_cmb1[7:6];
  assign ctrl_o.vert_diff_gain = r_cmb1[5:4];
  assign ctrl_o.median_gain = r_cmb1[3:2];
  assign ctrl_o.comb_threshold = r_cmb1[1:0];
  assign ctrl_o.vert_diff_threshold = r_cmb2[1:0];

  // ************************************************************
  // Host access
  // ************************************************************
  wire wr_hit = req_i.wr && (state == VDCR_IDLE);
  wire rd_hit = req_i.rd && !req_i.wr && (state == VDCR_IDLE);
  wire [7:0] status_one;
  wire [7:0] status_two;
  logic [7:0] rd_mux;

  assign status_one = {stat_i.standard_field_length, ~stat_i.horiz_locked,
                       stat_i.slow_time_const_active, stat_i.gain_top_limited,
                       stat_i.gain_bottom_limited, stat_i.white_peak_active,
                       stat_i.detected_colour_std};
  assign status_two = {interlace_sync,
                       ~(stat_i.horiz_locked & stat_i.vert_locked),
                       stat_i.field_rate_60, stat_i.stable_timebase,
                       stat_i.colourstripe_four_line,
                       stat_i.colourstripe_seen, stat_i.copy_protect_seen,
                       stat_i.capture_ready};

  always_comb
  begin
    case (req_i.addr)
      `VDCR_SA_MISC: rd_mux = r_misc;
      `VDCR_SA_GAIN: rd_mux = r_gain;
      `VDCR_SA_OFFS: rd_mux = r_offs;
      `VDCR_SA_KILL: rd_mux = r_kill;
      `VDCR_SA_CHRO: rd_mux = r_chro;
      `VDCR_SA_CMB1: rd_mux = r_cmb1;
      `VDCR_SA_CMB2: rd_mux = r_cmb2;
      `VDCR_SA_ST1: rd_mux = status_one;
      `VDCR_SA_ST2: rd_mux = status_two;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    case (state)
      VDCR_IDLE: next_state = wr_hit ? VDCR_WRITE :
                              rd_hit ? VDCR_READ : VDCR_IDLE;
      VDCR_WRITE: next_state = VDCR_IDLE;
      VDCR_READ: next_state = VDCR_IDLE;
      default: next_state = VDCR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      state <= VDCR_IDLE;
    else
      state <= next_state;
  end

  // status writes are dropped by the decode
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r_misc <= `VDCR_RST_MISC;
      r_gain <= `VDCR_RST_GAIN;
      r_offs <= `VDCR_RST_OFFS;
      r_kill <= `VDCR_RST_KILL;
      r_chro <= `VDCR_RST_CHRO;
      r_cmb1 <= `VDCR_RST_CMB1;
      r_cmb2 <= `VDCR_RST_CMB2;
    end
    else if (wr_hit)
    begin
      case (req_i.addr)
        `VDCR_SA_MISC: r_misc <= req_i.wdata;
        `VDCR_SA_GAIN: r_gain <= req_i.wdata;
        `VDCR_SA_OFFS: r_offs <= req_i.wdata;
        `VDCR_SA_KILL: r_kill <= req_i.wdata;
        `VDCR_SA_CHRO: r_chro <= req_i.wdata;
        `VDCR_SA_CMB1: r_cmb1 <= req_i.wdata;
        `VDCR_SA_CMB2: r_cmb2 <= req_i.wdata;
        default: r_misc <= r_misc;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_hit;
      if (rd_hit)
        rdata_o <= rd_mux;
    end
  end

  // ************************************************************
  // Raw data path
  // ************************************************************
  // Gain 128 is unity, so the product is shifted by seven; the
  // result saturates instead of wrapping at double amplitude
  wire [15:0] gain_prod = 16'(raw_data_i) * 16'(r_gain);
  wire [8:0] scaled = gain_prod[15:7];
  wire signed [10:0] with_offs = $signed({2'h0, scaled}) +
                                 $signed({3'h0, r_offs}) - 11'sd128;
  logic [7:0] next_raw;

  always_comb
  begin
    if (with_offs < 11'sd0)
      next_raw = 8'h00;
    else if (with_offs > 11'sd255)
      next_raw = 8'hff;
    else
      next_raw = with_offs[7:0];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      raw_data_o <= 8'h00;
    else
      raw_data_o <= next_raw;
  end

  // ************************************************************
  // Clock outputs and chroma controls
  // ************************************************************
  // enables active low
  assign line_clk_o = line_clk_i;
  assign line_clk_oe_n_o = r_misc[7];
  assign half_line_clk_o = half_line_clk_i;
  assign half_line_clk_oe_n_o = r_misc[6];

  assign killer_thr_o = (stat_i.detected_colour_std == VDCR_STD_SECAM) ?
                        r_kill[3:0] : r_kill[7:4];
  assign colour_limit_o = r_chro[1];

  // ************************************************************
  // Submodules
  // ************************************************************
  vdcr_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(interlace_pin_i),
    .q_o(interlace_sync)
  );

  vdcr_field_ctl u_field (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .field_start_i(field_start_i),
    .line_start_i(line_start_i),
    .field2_i(field2_i),
    .line_num_i(line_num_i),
    .gate_start_i({r_misc[0], gate_start_lsb_i}),
    .gate_stop_i({r_misc[1], gate_stop_lsb_i}),
    .alt_gate_i(r_misc[2]),
    .latency_i(r_misc[5:3]),
    .fast_seq_i(r_chro[0]),
    .vertical_window_pulse_o(vertical_window_pulse_o),
    .std_search_step_o(std_search_step_o),
    .seq_correct_o(seq_correct_o)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_write_status;
    req_i.wr && state == VDCR_IDLE && req_i.addr >= `VDCR_SA_ST1;
  endsequence

  a_status_ro_misc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_write_status |=> $stable(r_misc) && $stable(r_cmb2))
    else $error("status write changed a register");
  a_read_latency: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_hit |=> rvalid_o && rdata_o == $past(rd_mux))
    else $error("read data wrong");
  a_gate_msb_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_hit && req_i.addr == `VDCR_SA_MISC |=> ctrl_o.gate_start_msb == $past(req_i.wdata[0]) && ctrl_o.gate_stop_msb == $past(req_i.wdata[1]))
    else $error("gate msb not stored");
  a_clk_enable_n: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    line_clk_oe_n_o == ctrl_o.line_clock_out_en_n && half_line_clk_oe_n_o == r_misc[6])
    else $error("clock enable wrong");
  a_gain_nominal: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    r_gain == `VDCR_GAIN_NOM && r_offs == `VDCR_OFFS_ZERO && $stable(r_gain) && $stable(r_offs) |=> raw_data_o == $past(raw_data_i))
    else $error("nominal gain not unity");
  a_gain_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    r_gain == 8'h00 && $stable(r_gain) && $stable(r_offs) |=> raw_data_o == ($past(r_offs) >= 8'h80 ? $past(r_offs) - 8'h80 : 8'h00))
    else $error("offset wrong with gain off");
  a_killer_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    stat_i.detected_colour_std != VDCR_STD_SECAM |-> killer_thr_o == r_kill[7:4])
    else $error("killer threshold wrong");
  a_status_one_lock: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_hit && req_i.addr == `VDCR_SA_ST1 |=> rdata_o[6] == !$past(stat_i.horiz_locked) && rdata_o[1:0] == $past(stat_i.detected_colour_std))
    else $error("status one wrong");
  a_status_two_loops: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_hit && req_i.addr == `VDCR_SA_ST2 |=> rdata_o[6] == !($past(stat_i.horiz_locked) && $past(stat_i.vert_locked)) && rdata_o[5] == $past(stat_i.field_rate_60))
    else $error("status two wrong");
  a_seq_per_field: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !r_chro[0] && $stable(r_chro) && !field_start_i |=> !seq_correct_o)
    else $error("sequence strobe outside field start");

  // Gate only moves on a line strobe, so a settling line count
  // between strobes can never toggle it
  sequence s_no_line_strobe;
    !line_start_i;
  endsequence

  a_gate_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_no_line_strobe |=> $stable(vertical_window_pulse_o))
    else $error("gate moved without line strobe");
  a_step_on_field: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !field_start_i |=> !std_search_step_o)
    else $error("search step without field start");
  a_step_one_field: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    field_start_i && r_misc[5:3] == 3'h1 |=> std_search_step_o)
    else $error("latency one missed a step");
  a_clk_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    line_clk_o == line_clk_i && half_line_clk_o == half_line_clk_i)
    else $error("clock pin level wrong");
  a_killer_secam: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    stat_i.detected_colour_std == VDCR_STD_SECAM |-> killer_thr_o == r_kill[3:0])
    else $error("secam killer threshold wrong");
  a_status_one_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_hit && req_i.addr == `VDCR_SA_ST1 |=> rdata_o[5:2] == $past({stat_i.slow_time_const_active, stat_i.gain_top_limited, stat_i.gain_bottom_limited, stat_i.white_peak_active}))
    else $error("status one flags wrong");
  a_status_two_rate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_hit && req_i.addr == `VDCR_SA_ST2 |=> rdata_o[5:4] == $past({stat_i.field_rate_60, stat_i.stable_timebase}))
    else $error("status two rate wrong");

endmodule // vdcr_regs
`default_nettype wire

// ==== rtl/vdcr_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
`include "vdcr_cfg.svh"

module vdcr_sync (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Async reset, active high
  input wire logic d_i,       // Asynchronous level
  output logic q_o            // Filtered level
);
  logic [`VDCR_SYNC_STAGES-1:0] stage;
  logic next_q;

  // Stage 0 feeds stage 1 only; the filter looks at stages 1 and 2
  assign next_q = (stage[1] == stage[2]) ? stage[2] : q_o;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage <= '0;
      q_o <= 1'b0;
    end
    else
    begin
      stage <= {stage[1:0], d_i};
      q_o <= next_q;
    end
  end
endmodule // vdcr_sync
`default_nettype wire

// ==== test/vdcr_host_model.sv ====
// Host model issuing subaddress reads and writes on the strobe port
`timescale 1ns/1ps
`default_nettype none

module vdcr_host_model (
  input wire logic clk_sys_i,          // System clock
  input wire logic [7:0] rdata_i,      // Read data
  input wire logic rvalid_i,           // Read valid pulse
  output var vdcr_pkg::vdcr_req_t req_o // Host access
);
  import vdcr_pkg::*;

  initial req_o = '0;

  // Released lines flip so a stale address never reads as a live one
  task automatic release_bus();
    req_o.wr <= 1'b0;
    req_o.rd <= 1'b0;
    req_o.addr <= ~req_o.addr;
    req_o.wdata <= ~req_o.wdata;
  endtask

  // One access every two cycles, strobe held for one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req_o.wr <= 1'b1;
    req_o.addr <= a;
    req_o.wdata <= d;
    @(posedge clk_sys_i);
    release_bus();
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
    @(posedge clk_sys_i);
    req_o.rd <= 1'b1;
    req_o.addr <= a;
    @(posedge clk_sys_i);
    release_bus();
    @(posedge clk_sys_i);
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule // vdcr_host_model

`default_nettype wire

// ==== test/video_decoder_ctrl_status_regs_tb_top.sv ====
// Self-checking bench for the decoder control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "vdcr_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end

module video_decoder_ctrl_status_regs_tb_top;
  import vdcr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  vdcr_req_t req;
  vdcr_status_t stat = '0;
  vdcr_ctrl_t ctrl;
  logic [7:0] rdata, raw_in = '0, raw_out, lsb0 = '0, lsb1 = '0;
  logic rvalid, intl = 0, fs = 0, ls = 0, f2 = 0, lclk = 1, hclk = 0;
  logic lco, lcoe, hco, hcoe, vwin, step, seq, climit;
  logic [8:0] lnum = '0;
  logic [3:0] kthr;
  int num_errors = 0;
  int checks = 0;

  initial forever #2 clk_sys_i = ~clk_sys_i;

  vdcr_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .req_o(req));

  vdcr_regs DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .stat_i(stat),
    .interlace_pin_i(intl), .field_start_i(fs), .line_start_i(ls),
    .field2_i(f2), .line_num_i(lnum), .gate_start_lsb_i(lsb0),
    .gate_stop_lsb_i(lsb1), .raw_data_i(raw_in), .line_clk_i(lclk),
    .half_line_clk_i(hclk), .ctrl_o(ctrl), .raw_data_o(raw_out),
    .line_clk_o(lco), .line_clk_oe_n_o(lcoe), .half_line_clk_o(hco),
    .half_line_clk_oe_n_o(hcoe), .vertical_window_pulse_o(vwin),
    .std_search_step_o(step), .seq_correct_o(seq), .killer_thr_o(kthr),
    .colour_limit_o(climit));

  task automatic complete_run();
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // Field checks after each register write
  // ****************************************
  task automatic check_ctrl(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    case (a)
      8'h17:
      begin
        `CHK({ctrl.gate_stop_msb, ctrl.gate_start_msb}, v[1:0])
        `CHK(ctrl.alt_gate_position, v[2])
        `CHK(ctrl.std_search_latency, v[5:3])
        `CHK({lcoe, hcoe}, v[7:6])
        `CHK({lco, hco}, {lclk, hclk})
      end
      8'h18: `CHK(ctrl.raw_gain_code, v)
      8'h19: `CHK(ctrl.raw_offset_code, v)
      8'h1a: `CHK({ctrl.quad_killer_threshold,
                   ctrl.secam_killer_threshold}, v)
      8'h1b:
      begin
        `CHK(ctrl.vcr_detect_threshold, v[7:6])
        `CHK({climit, ctrl.colour_limit_en}, {2{v[1]}})
        `CHK(ctrl.fast_sequence_correct, v[0])
      end
      8'h1c: `CHK({ctrl.horiz_diff_gain, ctrl.vert_diff_gain,
        ctrl.median_gain, ctrl.comb_threshold}, v)
      default: `CHK(ctrl.vert_diff_threshold, v[1:0])
    endcase
  endtask

  // One line or field strobe, then one edge for the registered answer
  task automatic pulse_in(input logic [8:0] n, input logic f);
    lnum <= n;
    ls <= !f;
    fs <= f;
    @(posedge clk_sys_i);
    ls <= 1'b0;
    fs <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  function automatic logic [7:0] raw_exp(int g, int o, int x);
    int r;
    r = ((x * g) >> 7) + o - 128;
    return (r < 0) ? 8'h00 : (r > 255) ? 8'hff : 8'(r);
  endfunction

  initial
  begin
    logic [7:0] sa [7] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d};
    logic [7:0] rv [7] = '{8'h18, 8'h40, 8'h80, 8'h77, 8'h42, 8'ha9, 8'h01};
    logic [7:0] wv [7] = '{8'h95, 8'h3c, 8'hc3, 8'h5a, 8'h69, 8'h96, 8'h0e};
    int rw [4][3] = '{'{128, 128, 55}, '{255, 255, 200}, '{0, 0, 16},
                      '{128, 0, 200}};
    logic [15:0] sp [2] = '{16'hc5a3, 16'h5a3c};
    logic [7:0] d, e1, e2, val;
    logic v;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      host.rd_reg(sa[i], d, v);
      `CHK({v, d}, {1'b1, rv[i]})
      for (int k = 0; k < 2; k++)
      begin
        val = k ? ~wv[i] : wv[i];
        host.wr_reg(sa[i], val);
        check_ctrl(sa[i], val);
        host.rd_reg(sa[i], d, v);
        `CHK(d, val)
      end
    end
    // ****************************************
    // Live status, ignored writes, killer select
    // ****************************************
    foreach (sp[j])
    begin
      stat <= vdcr_status_t'(sp[j]);
      intl <= sp[j][0];
      repeat (6) @(posedge clk_sys_i);
      e1 = {stat.standard_field_length, ~stat.horiz_locked,
        stat.slow_time_const_active, stat.gain_top_limited,
        stat.gain_bottom_limited, stat.white_peak_active,
        stat.detected_colour_std};
      e2 = {intl, ~(stat.horiz_locked & stat.vert_locked),
        stat.field_rate_60, stat.stable_timebase,
        stat.colourstripe_four_line, stat.colourstripe_seen,
        stat.copy_protect_seen, stat.capture_ready};
      host.wr_reg(8'h1e, ~e1);
      host.wr_reg(8'h1f, ~e2);
      host.rd_reg(8'h1e, d, v);
      `CHK(d, e1)
      host.rd_reg(8'h1f, d, v);
      `CHK(d, e2)
      `CHK(kthr, (j == 0) ? 4'h5 : 4'ha)
    end
    host.rd_reg(8'h20, d, v);
    `CHK(d, 8'h00)
    // ****************************************
    // Raw path scaling and sequence strobe
    // ****************************************
    foreach (rw[j])
    begin
      host.wr_reg(8'h18, 8'(rw[j][0]));
      host.wr_reg(8'h19, 8'(rw[j][1]));
      raw_in <= 8'(rw[j][2]);
      repeat (2) @(posedge clk_sys_i);
      `CHK(raw_out, raw_exp(rw[j][0], rw[j][1], rw[j][2]))
    end
    for (int m = 0; m < 4; m++)
    begin
      host.wr_reg(8'h1b, {7'h21, m[1]});
      @(posedge clk_sys_i);
      fs <= ~m[0];
      ls <= m[0];
      @(posedge clk_sys_i);
      fs <= 1'b0;
      ls <= 1'b0;
      @(posedge clk_sys_i);
      `CHK(seq, m[1] ~^ m[0])
    end
    // ****************************************
    // Search latency and vertical gate
    // ****************************************
    host.wr_reg(8'h17, 8'h08);
    lsb0 <= 8'h0a;
    lsb1 <= 8'h0c;
    pulse_in(9'h000, 1'b1);
    `CHK(step, 1'b1)
    host.wr_reg(8'h17, 8'h38);
    for (int n = 0; n < 7; n++)
    begin
      pulse_in(9'h000, 1'b1);
      `CHK(step, n == 6)
    end
    pulse_in(9'h00a, 1'b0);
    `CHK(vwin, 1'b1)
    pulse_in(9'h00c, 1'b0);
    `CHK(vwin, 1'b0)
    host.wr_reg(8'h17, 8'h3c);
    f2 <= 1'b1;
    pulse_in(9'h009, 1'b0);
    `CHK(vwin, 1'b1)
    pulse_in(9'h00b, 1'b0);
    `CHK(vwin, 1'b0)
    host.wr_reg(8'h17, 8'h39);
    f2 <= 1'b0;
    pulse_in(9'h00a, 1'b0);
    `CHK(vwin, 1'b0)
    pulse_in(9'h10a, 1'b0);
    `CHK(vwin, 1'b1)
    complete_run();
  end

  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule // video_decoder_ctrl_status_regs_tb_top

`default_nettype wire
